//--- rtl/ptsr_pkg.sv
// Purpose: constants for the protection threshold and status register bank
// Assumes: byte-wide register port with 8-bit offsets
// Notes: threshold codes are decoded in ptsr_regs into the trip levels listed here
package ptsr_pkg;
  localparam logic [7:0] KEY_OFFS = 8'h00;
  localparam logic [7:0] KEY_LOCK_VALUE = 8'hA6;
  localparam logic [7:0] SUM_DELAY_OFFS = 8'h23;
  localparam logic [7:0] SUM_ADJ_OFFS = 8'h24;
  localparam logic [7:0] ABS_OV_OFFS = 8'h25;
  localparam logic [7:0] REL_OV_OFFS = 8'h26;
  localparam logic [7:0] UV_OFFS = 8'h27;
  localparam logic [7:0] OT_OFFS = 8'h28;
  localparam logic [7:0] DISABLE_OFFS = 8'h29;
  localparam logic [7:0] FAULT_OFFS = 8'h2A;
  localparam logic [7:0] PHASE_OFFS = 8'h2B;
  localparam logic [7:0] PHASE_EN_OFFS = 8'h4D;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [1:0] SUM_DELAY_RESET = 2'h1;
  localparam logic [5:0] SUM_ADJ_RESET = 6'h00;
  localparam logic [1:0] CODE2_RESET = 2'h0;
  localparam logic [4:0] DISABLE_RESET = 5'h00;
  localparam int SUM_DIR_BIT = 5;
  localparam int MONPIN_OT_BIT = 4;
  localparam int INT_OT_BIT = 3;
  localparam int SUM_OC_BIT = 2;
  localparam int UV_BIT = 1;
  localparam int OV_BIT = 0;
  localparam int NUM_PHASES = 8;
  // trip levels in millivolts, percent and degrees C
  localparam logic [11:0] SUM_BASE_MV = 12'h898;
  localparam logic [11:0] SUM_STEP_MV = 12'h032;
  localparam logic [11:0] ABS_OV_MV_00 = 12'h7D0;
  localparam logic [11:0] ABS_OV_MV_01 = 12'h708;
  localparam logic [11:0] ABS_OV_MV_10 = 12'h898;
  localparam logic [11:0] ABS_OV_MV_11 = 12'h960;
  localparam logic [7:0] REL_OV_PCT_00 = 8'h96;
  localparam logic [7:0] REL_OV_PCT_01 = 8'h8C;
  localparam logic [7:0] REL_OV_PCT_10 = 8'h82;
  localparam logic [7:0] REL_OV_PCT_11 = 8'h78;
  localparam logic [7:0] UV_PCT_00 = 8'h28;
  localparam logic [7:0] UV_PCT_01 = 8'h1E;
  localparam logic [7:0] UV_PCT_10 = 8'h32;
  localparam logic [7:0] UV_PCT_11 = 8'h3C;
  localparam logic [7:0] OT_DEG_00 = 8'h96;
  localparam logic [7:0] OT_DEG_01 = 8'hA0;
  localparam logic [7:0] OT_DEG_10 = 8'hAA;
  localparam logic [7:0] OT_DEG_11 = 8'h8C;
  // sum overcurrent persistence times in microseconds and cycles at 40 MHz
  localparam int CLK_MHZ = 40;
  localparam int SUM_DELAY_US_00 = 112;
  localparam int SUM_DELAY_US_01 = 56;
  localparam int SUM_DELAY_US_10 = 28;
  localparam int SUM_DELAY_US_11 = 14;
  localparam int SUM_DELAY_CYC_00 = SUM_DELAY_US_00 * CLK_MHZ;
  localparam int SUM_DELAY_CYC_01 = SUM_DELAY_US_01 * CLK_MHZ;
  localparam int SUM_DELAY_CYC_10 = SUM_DELAY_US_10 * CLK_MHZ;
  localparam int SUM_DELAY_CYC_11 = SUM_DELAY_US_11 * CLK_MHZ;
  localparam int DELAY_W = 13;
  typedef enum logic [1:0] {
    PTSR_SUM_IDLE = 2'b00,
    PTSR_SUM_COUNT = 2'b01,
    PTSR_SUM_TRIP = 2'b10
  } ptsr_sum_state_t;
endpackage

//--- rtl/ptsr_sum_delay.sv
// Purpose: persistence timer for the sum overcurrent comparator
// Assumes: comparator input already synchronised; limit fixed while counting
// Notes: a trip is a one-cycle pulse after the condition held limit cycles
module ptsr_sum_delay (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // condition and result
  input wire logic cond,
  input wire logic [ptsr_pkg::DELAY_W-1:0] limit,
  output logic trip
);
  import ptsr_pkg::*;
  ptsr_sum_state_t state_reg, state_next;
  logic [DELAY_W-1:0] count_reg, count_next;
  wire logic reached = (count_reg >= limit - 13'h0001);

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      PTSR_SUM_IDLE: begin
        count_next = '0;
        if (cond) state_next = PTSR_SUM_COUNT;
      end
      PTSR_SUM_COUNT: begin
        // any drop of the condition restarts the wait
        if (!cond) state_next = PTSR_SUM_IDLE;
        else if (reached) state_next = PTSR_SUM_TRIP;
        else count_next = count_reg + 13'h0001;
      end
      PTSR_SUM_TRIP: begin
        count_next = '0;
        if (!cond) state_next = PTSR_SUM_IDLE;
      end
      default: state_next = PTSR_SUM_IDLE;
    endcase
  end

  assign trip = (state_reg == PTSR_SUM_COUNT) && cond && reached;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= PTSR_SUM_IDLE;
      count_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end
endmodule

//--- rtl/ptsr_regs.sv
// Purpose: protection threshold, disable and fault indication registers
// Assumes: byte register port from the serial bus engine, one-cycle strobes
// Notes: comparator inputs are asynchronous and pass three flip-flops
// Notes on behaviour
// - Writes to protection settings are ignored while the key register holds 0xA6.
// - Bit 5 of the sum trip adjustment selects raise (0) or lower (1).
// - Sum trip level is 2.2 V plus or minus the five-bit offset times 50 mV, offset reset zero.
// - Absolute overvoltage code 00/01/10/11 gives 2.0/1.8/2.2/2.4 V.
// - Relative overvoltage code 00/01/10/11 gives 150/140/130/120 percent of reference.
// - Undervoltage code 00/01/10/11 gives 40/30/50/60 percent of reference.
// - Overtemperature code 00/01/10/11 gives 150/160/170/140 degrees C.
// - Disable bits 4 and 3 turn off monitor-pin and internal overtemperature protection.
// - Disable bits 2, 1 and 0 turn off sum overcurrent, undervoltage and overvoltage.
// - A read-only register reports fired protections in bits 4 down to 0.
// - A read-only register holds one overcurrent flag per phase, phase n at bit n-1.
// - The per-phase register updates only while the enable bit is one, else it reads zero.
// - Sum overcurrent must persist for the programmed delay before it trips.
module ptsr_regs (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // register port
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // comparator inputs, asynchronous
  input wire logic sum_oc_in,
  input wire logic ov_in,
  input wire logic uv_in,
  input wire logic int_ot_in,
  input wire logic monpin_ot_in,
  input wire logic [ptsr_pkg::NUM_PHASES-1:0] phase_oc_in,
  // decoded thresholds, protection enables and fault flags
  output logic [11:0] sum_trip_mv,
  output logic [11:0] abs_ov_mv,
  output logic [7:0] rel_ov_pct,
  output logic [7:0] uv_pct,
  output logic [7:0] ot_deg,
  output logic [4:0] prot_enable,
  output logic [4:0] fault_flags
);
  import ptsr_pkg::*;

  function automatic logic [7:0] pick4(input logic [1:0] c, input logic [7:0] a, input logic [7:0] b,
                                       input logic [7:0] d, input logic [7:0] e);
    case (c)
      2'h0: pick4 = a;
      2'h1: pick4 = b;
      2'h2: pick4 = d;
      default: pick4 = e;
    endcase
  endfunction

  logic [7:0] key_reg;
  logic [7:0] phase_en_reg;
  logic [1:0] delay_reg;
  logic [5:0] adj_reg;
  logic [1:0] abs_ov_reg, rel_ov_reg, uv_reg, ot_reg;
  logic [4:0] dis_reg;
  logic [4:0] fault_reg, fault_next;
  logic [7:0] phase_reg, phase_next;
  logic [12:0] s1_reg, s2_reg, s3_reg;
  logic [7:0] rdata_reg;

  // three-stage sync; a level counts once stages two and three agree
  wire logic [12:0] raw_in = {phase_oc_in, monpin_ot_in, int_ot_in, sum_oc_in, uv_in, ov_in};
  logic [12:0] cond_reg;
  wire logic [12:0] agree = ~(s2_reg ^ s3_reg);
  wire logic [12:0] cond_next = (agree & s2_reg) | (~agree & cond_reg);

  wire logic unlocked = (key_reg != KEY_LOCK_VALUE);
  wire logic cfg_we = wr_en && unlocked;

  wire logic [DELAY_W-1:0] delay_limit =
    (delay_reg == 2'h0) ? DELAY_W'(SUM_DELAY_CYC_00) :
    (delay_reg == 2'h1) ? DELAY_W'(SUM_DELAY_CYC_01) :
    (delay_reg == 2'h2) ? DELAY_W'(SUM_DELAY_CYC_10) : DELAY_W'(SUM_DELAY_CYC_11);
  wire logic sum_trip;
  ptsr_sum_delay u_delay (
    .clk(clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .cond(cond_reg[SUM_OC_BIT] && prot_enable[SUM_OC_BIT]),
    .limit(delay_limit),
    .trip(sum_trip)
  );

  wire logic [11:0] sum_off_mv = 12'(adj_reg[4:0] * SUM_STEP_MV);
  assign sum_trip_mv = adj_reg[SUM_DIR_BIT] ? SUM_BASE_MV - sum_off_mv : SUM_BASE_MV + sum_off_mv;
  assign abs_ov_mv = (abs_ov_reg == 2'h0) ? ABS_OV_MV_00 : (abs_ov_reg == 2'h1) ? ABS_OV_MV_01 :
                     (abs_ov_reg == 2'h2) ? ABS_OV_MV_10 : ABS_OV_MV_11;
  assign rel_ov_pct = pick4(rel_ov_reg, REL_OV_PCT_00, REL_OV_PCT_01, REL_OV_PCT_10, REL_OV_PCT_11);
  assign uv_pct = pick4(uv_reg, UV_PCT_00, UV_PCT_01, UV_PCT_10, UV_PCT_11);
  assign ot_deg = pick4(ot_reg, OT_DEG_00, OT_DEG_01, OT_DEG_10, OT_DEG_11);
  assign prot_enable = ~dis_reg;

  // events are gated by their enables and kept sticky
  wire logic [4:0] fault_set = {cond_reg[4:3], sum_trip, cond_reg[1:0]} & prot_enable;
  assign fault_next = fault_reg | fault_set;
  wire logic phase_on = phase_en_reg[0];
  assign phase_next = phase_on ? (phase_reg | cond_reg[12:5]) : 8'h00;
  assign fault_flags = fault_reg;

  wire logic [7:0] rd_mux =
    (addr == KEY_OFFS) ? key_reg :
    (addr == SUM_DELAY_OFFS) ? {6'h00, delay_reg} :
    (addr == SUM_ADJ_OFFS) ? {2'h0, adj_reg} :
    (addr == ABS_OV_OFFS) ? {6'h00, abs_ov_reg} :
    (addr == REL_OV_OFFS) ? {6'h00, rel_ov_reg} :
    (addr == UV_OFFS) ? {6'h00, uv_reg} :
    (addr == OT_OFFS) ? {6'h00, ot_reg} :
    (addr == DISABLE_OFFS) ? {3'h0, dis_reg} :
    (addr == FAULT_OFFS) ? {3'h0, fault_reg} :
    (addr == PHASE_OFFS) ? phase_reg :
    (addr == PHASE_EN_OFFS) ? phase_en_reg : 8'h00;
  assign rdata = rdata_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      cond_reg <= '0;
    end else if (clk_en) begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      cond_reg <= cond_next;
    end
  end

  // key and per-phase enable are writable even when locked, else no unlock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      key_reg <= KEY_RESET;
      phase_en_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end else if (clk_en) begin
      if (wr_en && addr == KEY_OFFS) key_reg <= wdata;
      if (wr_en && addr == PHASE_EN_OFFS) phase_en_reg <= wdata;
      if (rd_en) rdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      delay_reg <= SUM_DELAY_RESET;
      adj_reg <= SUM_ADJ_RESET;
      abs_ov_reg <= CODE2_RESET;
      rel_ov_reg <= CODE2_RESET;
      uv_reg <= CODE2_RESET;
      ot_reg <= CODE2_RESET;
      dis_reg <= DISABLE_RESET;
    end else if (clk_en && cfg_we) begin
      if (addr == SUM_DELAY_OFFS) delay_reg <= wdata[1:0];
      if (addr == SUM_ADJ_OFFS) adj_reg <= wdata[5:0];
      if (addr == ABS_OV_OFFS) abs_ov_reg <= wdata[1:0];
      if (addr == REL_OV_OFFS) rel_ov_reg <= wdata[1:0];
      if (addr == UV_OFFS) uv_reg <= wdata[1:0];
      if (addr == OT_OFFS) ot_reg <= wdata[1:0];
      if (addr == DISABLE_OFFS) dis_reg <= wdata[4:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_reg <= 5'h00;
      phase_reg <= 8'h00;
    end else if (clk_en) begin
      fault_reg <= fault_next;
      phase_reg <= phase_next;
    end
  end

  lock_blocks_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && wr_en && addr == ABS_OV_OFFS && key_reg == KEY_LOCK_VALUE |=> $stable(abs_ov_reg))
    else $error("locked write changed a setting");
  lock_all_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && wr_en && !unlocked |=> $stable({delay_reg, adj_reg, abs_ov_reg, rel_ov_reg, uv_reg, ot_reg, dis_reg}))
    else $error("locked write changed settings");
  key_write_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && wr_en && addr == KEY_OFFS |=> key_reg == $past(wdata))
    else $error("key write lost");
  unlock_writes_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && wr_en && addr == DISABLE_OFFS && key_reg != KEY_LOCK_VALUE |=> dis_reg == $past(wdata[4:0]))
    else $error("unlocked write lost");
  delay_write_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && wr_en && addr == SUM_DELAY_OFFS && unlocked |=> delay_reg == $past(wdata[1:0]))
    else $error("delay write lost");
  adj_write_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && wr_en && addr == SUM_ADJ_OFFS && unlocked |=> adj_reg == $past(wdata[5:0]))
    else $error("adjust write lost");
  ot_write_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && wr_en && addr == OT_OFFS && unlocked |=> ot_reg == $past(wdata[1:0]))
    else $error("overtemp write lost");
  sum_level_a: assert property (@(posedge clk) disable iff (!nrst)
    adj_reg[SUM_DIR_BIT] |-> sum_trip_mv <= SUM_BASE_MV)
    else $error("lowering raised sum level");
  sum_raise_a: assert property (@(posedge clk) disable iff (!nrst)
    !adj_reg[SUM_DIR_BIT] |-> sum_trip_mv >= SUM_BASE_MV)
    else $error("raising lowered sum level");
  sum_base_a: assert property (@(posedge clk) disable iff (!nrst)
    adj_reg[4:0] == 5'h00 |-> sum_trip_mv == SUM_BASE_MV)
    else $error("sum base level wrong");
  sum_step_a: assert property (@(posedge clk) disable iff (!nrst)
    adj_reg == 6'h21 |-> sum_trip_mv == SUM_BASE_MV - SUM_STEP_MV)
    else $error("sum step wrong");
  abs_code0_a: assert property (@(posedge clk) disable iff (!nrst)
    abs_ov_reg == 2'h0 |-> abs_ov_mv == ABS_OV_MV_00)
    else $error("absolute level wrong");
  abs_code1_a: assert property (@(posedge clk) disable iff (!nrst)
    abs_ov_reg == 2'h1 |-> abs_ov_mv == ABS_OV_MV_01)
    else $error("absolute level wrong");
  abs_code2_a: assert property (@(posedge clk) disable iff (!nrst)
    abs_ov_reg == 2'h2 |-> abs_ov_mv == ABS_OV_MV_10)
    else $error("absolute level wrong");
  abs_code3_a: assert property (@(posedge clk) disable iff (!nrst)
    abs_ov_reg == 2'h3 |-> abs_ov_mv == ABS_OV_MV_11)
    else $error("absolute level wrong");
  rel_code0_a: assert property (@(posedge clk) disable iff (!nrst)
    rel_ov_reg == 2'h0 |-> rel_ov_pct == REL_OV_PCT_00)
    else $error("relative level wrong");
  rel_code1_a: assert property (@(posedge clk) disable iff (!nrst)
    rel_ov_reg == 2'h1 |-> rel_ov_pct == REL_OV_PCT_01)
    else $error("relative level wrong");
  rel_code2_a: assert property (@(posedge clk) disable iff (!nrst)
    rel_ov_reg == 2'h2 |-> rel_ov_pct == REL_OV_PCT_10)
    else $error("relative level wrong");
  rel_code3_a: assert property (@(posedge clk) disable iff (!nrst)
    rel_ov_reg == 2'h3 |-> rel_ov_pct == REL_OV_PCT_11)
    else $error("relative level wrong");
  uv_code0_a: assert property (@(posedge clk) disable iff (!nrst)
    uv_reg == 2'h0 |-> uv_pct == UV_PCT_00)
    else $error("undervoltage level wrong");
  uv_code1_a: assert property (@(posedge clk) disable iff (!nrst)
    uv_reg == 2'h1 |-> uv_pct == UV_PCT_01)
    else $error("undervoltage level wrong");
  uv_code2_a: assert property (@(posedge clk) disable iff (!nrst)
    uv_reg == 2'h2 |-> uv_pct == UV_PCT_10)
    else $error("undervoltage level wrong");
  uv_code3_a: assert property (@(posedge clk) disable iff (!nrst)
    uv_reg == 2'h3 |-> uv_pct == UV_PCT_11)
    else $error("undervoltage level wrong");
  ot_code0_a: assert property (@(posedge clk) disable iff (!nrst)
    ot_reg == 2'h0 |-> ot_deg == OT_DEG_00)
    else $error("overtemp code wrong");
  ot_code1_a: assert property (@(posedge clk) disable iff (!nrst)
    ot_reg == 2'h1 |-> ot_deg == OT_DEG_01)
    else $error("overtemp code wrong");
  ot_code2_a: assert property (@(posedge clk) disable iff (!nrst)
    ot_reg == 2'h2 |-> ot_deg == OT_DEG_10)
    else $error("overtemp code wrong");
  ot_code_a: assert property (@(posedge clk) disable iff (!nrst)
    ot_reg == 2'h3 |-> ot_deg == OT_DEG_11)
    else $error("overtemp code wrong");
  fault_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && fault_reg[0] |=> fault_reg[0])
    else $error("fault flag dropped");
  sticky_all_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en |=> (fault_reg & $past(fault_reg)) == $past(fault_reg))
    else $error("fault flags dropped");
  disabled_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && dis_reg[UV_BIT] && !fault_reg[UV_BIT] |=> !fault_reg[UV_BIT])
    else $error("disabled protection flagged");
  ov_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && dis_reg[OV_BIT] && !fault_reg[OV_BIT] |=> !fault_reg[OV_BIT])
    else $error("disabled overvoltage flagged");
  sum_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && dis_reg[SUM_OC_BIT] && !fault_reg[SUM_OC_BIT] |=> !fault_reg[SUM_OC_BIT])
    else $error("disabled sum trip flagged");
  int_ot_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && dis_reg[INT_OT_BIT] && !fault_reg[INT_OT_BIT] |=> !fault_reg[INT_OT_BIT])
    else $error("disabled overtemp flagged");
  mon_ot_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && dis_reg[MONPIN_OT_BIT] && !fault_reg[MONPIN_OT_BIT] |=> !fault_reg[MONPIN_OT_BIT])
    else $error("disabled pin overtemp flagged");
  ov_set_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && cond_reg[OV_BIT] && !dis_reg[OV_BIT] |=> fault_reg[OV_BIT])
    else $error("overvoltage not flagged");
  uv_set_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && cond_reg[UV_BIT] && !dis_reg[UV_BIT] |=> fault_reg[UV_BIT])
    else $error("undervoltage not flagged");
  int_ot_set_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && cond_reg[INT_OT_BIT] && !dis_reg[INT_OT_BIT] |=> fault_reg[INT_OT_BIT])
    else $error("overtemp not flagged");
  mon_ot_set_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && cond_reg[MONPIN_OT_BIT] && !dis_reg[MONPIN_OT_BIT] |=> fault_reg[MONPIN_OT_BIT])
    else $error("pin overtemp not flagged");
  sum_set_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && sum_trip |=> fault_reg[SUM_OC_BIT])
    else $error("sum trip not flagged");
  phase_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && !phase_en_reg[0] |=> phase_reg == 8'h00)
    else $error("phase flags set while off");
  phase_set_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && phase_en_reg[0] && cond_reg[5] |=> phase_reg[0])
    else $error("phase one flag missed");
  phase_top_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && phase_en_reg[0] && cond_reg[12] |=> phase_reg[7])
    else $error("phase eight flag missed");
  phase_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && phase_en_reg[0] |=> (phase_reg & $past(phase_reg)) == $past(phase_reg))
    else $error("phase flag dropped");
  rd_fault_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && rd_en && addr == FAULT_OFFS |=> rdata == {3'h0, $past(fault_reg)})
    else $error("fault read wrong");
  rd_phase_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && rd_en && addr == PHASE_OFFS |=> rdata == $past(phase_reg))
    else $error("phase read wrong");
  freeze_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !clk_en |=> $stable({key_reg, phase_en_reg, delay_reg, adj_reg, abs_ov_reg, rel_ov_reg, uv_reg, ot_reg,
                         dis_reg, fault_reg, phase_reg, rdata_reg}))
    else $error("state moved while frozen");
  sum_wait_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(fault_reg[SUM_OC_BIT]) |-> $past(cond_reg[SUM_OC_BIT], 2))
    else $error("sum trip without persistence");
endmodule

//--- test/ptsr_host_model.sv
// Purpose: host side of the register port, issuing single-byte writes and reads
// Assumes: strobes are taken at the rising edge; read data lands one edge later
// Notes: write data parks at the inverse of the last byte so stale data never reads as valid
module ptsr_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule

//--- test/ptsr_regs_test.sv
// Purpose: self-checking bench for the protection register bank
// Assumes: comparator levels change at clock edges; clk_en is lowered once to check the freeze
// Notes: sum delay uses its shortest code to keep the run brief
module ptsr_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ptsr_pkg::*;
  logic clk, nrst, clk_en, wr_en, rd_en, sum_oc_in, ov_in, uv_in, int_ot_in, monpin_ot_in;
  logic [7:0] addr, wdata, rdata, rel_ov_pct, uv_pct, ot_deg, phase_oc_in;
  logic [11:0] sum_trip_mv, abs_ov_mv;
  logic [4:0] prot_enable, fault_flags;
  int n_fail = 0;
  int n_compared = 0;
  ptsr_host_model host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata));
  ptsr_regs dut_u (.clk(clk), .nrst(nrst), .clk_en(clk_en), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .sum_oc_in(sum_oc_in), .ov_in(ov_in), .uv_in(uv_in), .int_ot_in(int_ot_in),
    .monpin_ot_in(monpin_ot_in), .phase_oc_in(phase_oc_in), .sum_trip_mv(sum_trip_mv), .abs_ov_mv(abs_ov_mv),
    .rel_ov_pct(rel_ov_pct), .uv_pct(uv_pct), .ot_deg(ot_deg), .prot_enable(prot_enable),
    .fault_flags(fault_flags));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic report_and_stop;
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host_u.rd(a, v);
    chk({4'h0, v}, {4'h0, exp});
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check_reset;
    for (int a = 8'h23; a <= 8'h2B; a++) rchk(a[7:0], (a == 8'h23) ? 8'h01 : 8'h00);
    rchk(8'h7F, 8'h00);
    chk(sum_trip_mv, 12'h898);
    chk({7'h00, prot_enable}, 12'h01F);
  endtask
  task automatic check_codes;
    logic [11:0] abs_t[4] = '{12'h7D0, 12'h708, 12'h898, 12'h960};
    logic [7:0] rel_t[4] = '{8'h96, 8'h8C, 8'h82, 8'h78};
    logic [7:0] uv_t[4] = '{8'h28, 8'h1E, 8'h32, 8'h3C};
    logic [7:0] ot_t[4] = '{8'h96, 8'hA0, 8'hAA, 8'h8C};
    for (int c = 0; c < 4; c++) begin
      host_u.wr(8'h25, c[7:0]);
      host_u.wr(8'h26, c[7:0]);
      host_u.wr(8'h27, c[7:0]);
      host_u.wr(8'h28, c[7:0]);
      chk(abs_ov_mv, abs_t[c]);
      chk({4'h0, rel_ov_pct}, {4'h0, rel_t[c]});
      chk({4'h0, uv_pct}, {4'h0, uv_t[c]});
      chk({4'h0, ot_deg}, {4'h0, ot_t[c]});
    end
  endtask
  task automatic check_sum_adjust;
    host_u.wr(8'h24, 8'h1F);
    chk(sum_trip_mv, 12'h898 + 12'h01F * 12'h032);
    host_u.wr(8'h24, 8'h3F);
    chk(sum_trip_mv, 12'h898 - 12'h01F * 12'h032);
    host_u.wr(8'h24, 8'h21);
    chk(sum_trip_mv, 12'h898 - 12'h032);
    rchk(8'h24, 8'h21);
  endtask
  task automatic check_lock;
    host_u.wr(8'h00, 8'hA6);
    host_u.wr(8'h25, 8'h01);
    host_u.wr(8'h29, 8'h1F);
    host_u.wr(8'h23, 8'h00);
    chk(abs_ov_mv, 12'h960);
    chk({7'h00, prot_enable}, 12'h01F);
    rchk(8'h23, 8'h01);
    host_u.wr(8'h00, 8'h00);
    host_u.wr(8'h25, 8'h01);
    chk(abs_ov_mv, 12'h708);
  endtask
  task automatic check_faults;
    host_u.wr(8'h29, 8'h1F);
    @(posedge clk);
    {ov_in, uv_in, int_ot_in, monpin_ot_in} <= 4'hF;
    wait_cyc(10);
    chk({7'h00, fault_flags}, 12'h000);
    host_u.wr(8'h29, 8'h04);
    wait_cyc(6);
    chk({7'h00, fault_flags}, 12'h01B);
    {ov_in, uv_in, int_ot_in, monpin_ot_in} <= 4'h0;
    wait_cyc(10);
    host_u.wr(8'h2A, 8'h00);
    rchk(8'h2A, 8'h1B);
  endtask
  task automatic check_sum_delay;
    int n;
    host_u.wr(8'h29, 8'h00);
    host_u.wr(8'h23, 8'h03);
    @(posedge clk);
    sum_oc_in <= 1'b1;
    wait_cyc(300);
    sum_oc_in <= 1'b0;
    wait_cyc(10);
    chk({11'h000, fault_flags[2]}, 12'h000);
    sum_oc_in <= 1'b1;
    n = 0;
    while (fault_flags[2] !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 700) begin
        n_fail++;
        report_and_stop();
      end
    end
    chk({11'h000, (n >= 560 && n <= 570)}, 12'h001);
  endtask
  task automatic check_phase;
    @(posedge clk);
    phase_oc_in <= 8'h81;
    wait_cyc(10);
    rchk(8'h2B, 8'h00);
    host_u.wr(8'h4D, 8'h01);
    wait_cyc(10);
    phase_oc_in <= 8'h00;
    wait_cyc(10);
    rchk(8'h2B, 8'h81);
    host_u.wr(8'h4D, 8'h00);
    wait_cyc(2);
    rchk(8'h2B, 8'h00);
  endtask
  task automatic check_hold_reset;
    @(posedge clk);
    clk_en <= 1'b0;
    sum_oc_in <= 1'b0;
    host_u.wr(8'h25, 8'h02);
    chk(abs_ov_mv, 12'h708);
    chk({7'h00, fault_flags}, 12'h01F);
    @(posedge clk);
    clk_en <= 1'b1;
    @(posedge clk);
    nrst <= 1'b0;
    wait_cyc(3);
    chk({7'h00, fault_flags}, 12'h000);
    nrst <= 1'b1;
    check_reset();
  endtask
  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    {sum_oc_in, ov_in, uv_in, int_ot_in, monpin_ot_in} = 5'h00;
    phase_oc_in = 8'h00;
    wait_cyc(5);
    nrst <= 1'b1;
    check_reset();
    check_codes();
    check_sum_adjust();
    check_lock();
    check_faults();
    check_sum_delay();
    check_phase();
    check_hold_reset();
    report_and_stop();
  end
endmodule
